// >>> rtl/emb_cfg.v
// Contract
// R1: bit 4 clear selects multiplexed bus; set selects separate address and data pins.
// R2: top three configuration bits read zero; writes to them are ignored.
// R3: mode 00 sends every move on-chip, addresses alias into on-chip space.
// R4: mode 01 splits at 4 kB; 8-bit off-chip moves leave upper byte to port latch.
// R5: software must set page outside on-chip range to reach off-chip in mode 01.
// R6: mode 10 splits at 4 kB; 8-bit off-chip moves take upper byte from page.
// R7: mode 11 sends every move off-chip; on-chip RAM is invisible.
// R8: latch strobe high then low for 1 to 4 clocks by width code.
// R9: latch width applies only in multiplexed operation.
// R10: multiplexed operation shares eight pins for data and low address.
// R11: generate the latch strobe for the external address latch.
// R12: first multiplexed phase: strobe high, low address byte on shared pins.
// R13: external latch is transparent while strobe high, holds after it falls.
// R14: second phase carries data on shared pins when read or write strobe asserts.
// R15: non-multiplexed operation keeps address and data on separate pins.
// R16: an off-chip move lasts its timing parameters plus four clocks.
// R17: pins are claimed only during an off-chip move, released afterwards.
// R18: data drivers are off during a read.
// R19: internal-only mode wraps addresses on 4 kB boundaries.
// R20: read and write strobes active low, only one per access.
`timescale 1ns/10ps
`default_nettype none
`include "emb_cfg_regs.vh"
module emb_cfg (
   input  wire        core_clk,
   input  wire        rst_n,
   // special function register port
   input  wire [7:0]  sfr_addr,
   input  wire [7:0]  sfr_wdata,
   input  wire        sfr_wr,
   output reg  [7:0]  sfr_rdata,
   // move request from the core
   input  wire        move_req,
   input  wire        move_write,
   input  wire        move_8bit,
   input  wire [15:0] move_addr,
   input  wire [7:0]  move_wdata,
   input  wire [3:0]  strobe_width,
   output reg         move_done,
   output reg         move_onchip,
   output reg  [11:0] onchip_addr,
   output reg  [7:0]  move_rdata,
   output reg         move_busy,
   // external pins
   output reg         ale,
   output reg         rd_n,
   output reg         wr_n,
   output reg  [7:0]  ad_out,
   output reg         ad_oe,
   input  wire [7:0]  ad_in,
   output reg  [7:0]  addr_lo_out,
   output reg         addr_lo_oe,
   output reg  [7:0]  addr_hi_out,
   output reg         addr_hi_oe,
   output reg         pins_claimed
);
   ////////////////////////////////////////////////////////////////////////
   localparam ST_IDLE  = 3'h0;
   localparam ST_ALEHI = 3'h1;
   localparam ST_ALELO = 3'h2;
   localparam ST_STRB  = 3'h3;
   localparam ST_TAIL  = 3'h4;
   localparam [7:0] CFG_RST = `EMB_CFG_RESET;

   reg  [4:0] cfg;
   reg  [7:0] page;
   reg  [2:0] state;
   reg  [2:0] next_state;
   reg        is_write;
   reg  [7:0] wdata;
   reg  [7:0] ad_sync1;
   reg  [7:0] ad_sync2;
   reg        tload;
   reg  [3:0] tcount;
   // strobe length held for the whole move, the port may change meanwhile
   reg  [3:0] strb_len;
   wire       tdone;

   // R1: bit 4 picks bus style
   wire       mux_select_bit  = cfg[`EMB_MUX_BIT];
   wire [1:0] memory_map_mode = cfg[`EMB_MODE_HI:`EMB_MODE_LO];
   wire [1:0] latch_pulse_width = cfg[`EMB_ALE_HI:`EMB_ALE_LO];
   wire [3:0] ale_cycles = {2'h0, latch_pulse_width} + 4'h1;

   // effective address: 8-bit moves take the high byte from the page
   wire [15:0] eff_addr = move_8bit ? {page, move_addr[7:0]} : move_addr;
   wire        above    = |eff_addr[15:`EMB_ONCHIP_BITS];
   reg         go_off;
   always @* begin
      case (memory_map_mode)
         // R3: internal only
         `EMB_MODE_INT: go_off = 1'b0;
         // R7: external only
         `EMB_MODE_EXT: go_off = 1'b1;
         // R4: split at the 4 kB boundary
         default:       go_off = above;
      endcase
   end
   // R6: upper byte driven unless an 8-bit move in mode 01 or 11
   wire drive_hi = !(move_8bit && (memory_map_mode == `EMB_MODE_SPLIT_NB ||
                                   memory_map_mode == `EMB_MODE_EXT));

   ////////////////////////////////////////////////////////////////////////
   // R2: unused bits read zero
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg       <= CFG_RST[4:0];
         page      <= `EMB_PAGE_RESET;
         sfr_rdata <= 8'h00;
      end else begin
         if (sfr_wr && sfr_addr == `EMB_CFG_ADDR) begin
            cfg <= sfr_wdata[4:0];
         end
         if (sfr_wr && sfr_addr == `EMB_PAGE_ADDR) begin
            page <= sfr_wdata;
         end
         case (sfr_addr)
            `EMB_CFG_ADDR:  sfr_rdata <= {3'h0, cfg} & `EMB_CFG_WMASK;
            `EMB_PAGE_ADDR: sfr_rdata <= page;
            default:        sfr_rdata <= 8'h00;
         endcase
      end
   end

   // data pins from outside: two flops before use
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_sync1 <= 8'h00;
         ad_sync2 <= 8'h00;
      end else begin
         ad_sync1 <= ad_in;
         ad_sync2 <= ad_sync1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   emb_pulse_timer u_timer (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .load     (tload),
      .count_in (tcount),
      .done     (tdone)
   );

   always @* begin
      next_state = state;
      tload      = 1'b0;
      tcount     = 4'h0;
      case (state)
         ST_IDLE: begin
            if (move_req && go_off) begin
               tload = 1'b1;
               // R9: latch phases only when multiplexed
               if (!mux_select_bit) begin
                  next_state = ST_ALEHI;
                  tcount     = ale_cycles - 4'h1;
               end else begin
                  next_state = ST_STRB;
                  tcount     = strobe_width;
               end
            end
         end
         // R8: high phase width
         ST_ALEHI: begin
            if (tdone) begin
               next_state = ST_ALELO;
               tload      = 1'b1;
               tcount     = ale_cycles - 4'h1;
            end
         end
         ST_ALELO: begin
            if (tdone) begin
               next_state = ST_STRB;
               tload      = 1'b1;
               tcount     = strb_len;
            end
         end
         ST_STRB: begin
            if (tdone) begin
               next_state = ST_TAIL;
               tload      = 1'b1;
               tcount     = {1'b0, `EMB_MOVE_OVERHEAD} - 4'h2;
            end
         end
         ST_TAIL: begin
            if (tdone) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state        <= ST_IDLE;
         is_write     <= 1'b0;
         wdata        <= 8'h00;
         strb_len     <= 4'h0;
         move_done    <= 1'b0;
         move_onchip  <= 1'b0;
         onchip_addr  <= 12'h000;
         move_rdata   <= 8'h00;
         move_busy    <= 1'b0;
         ale          <= 1'b0;
         rd_n         <= 1'b1;
         wr_n         <= 1'b1;
         ad_out       <= 8'h00;
         ad_oe        <= 1'b0;
         addr_lo_out  <= 8'h00;
         addr_lo_oe   <= 1'b0;
         addr_hi_out  <= 8'h00;
         addr_hi_oe   <= 1'b0;
         pins_claimed <= 1'b0;
      end else begin
         state       <= next_state;
         move_done   <= 1'b0;
         move_onchip <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (move_req && !go_off) begin
                  // R19: wrap into the 4 kB on-chip space
                  onchip_addr <= eff_addr[11:0];
                  move_onchip <= 1'b1;
                  move_done   <= 1'b1;
               end else if (move_req) begin
                  // R17: claim pins for the off-chip move
                  pins_claimed <= 1'b1;
                  move_busy    <= 1'b1;
                  is_write     <= move_write;
                  wdata        <= move_wdata;
                  strb_len     <= strobe_width;
                  addr_hi_out  <= eff_addr[15:8];
                  addr_hi_oe   <= drive_hi;
                  if (!mux_select_bit) begin
                     // R12: strobe high with low address on shared pins
                     ale    <= 1'b1;
                     ad_out <= eff_addr[7:0];
                     ad_oe  <= 1'b1;
                  end else begin
                     // R15: address on its own pins
                     addr_lo_out <= eff_addr[7:0];
                     addr_lo_oe  <= 1'b1;
                     ad_out      <= move_wdata;
                     ad_oe       <= move_write;
                     // R20: one active-low strobe
                     rd_n        <= move_write;
                     wr_n        <= !move_write;
                  end
               end
            end
            ST_ALEHI: begin
               // R11: latch captures on falling edge
               if (tdone) begin
                  ale <= 1'b0;
               end
            end
            ST_ALELO: begin
               if (tdone) begin
                  // R14: data on shared pins with strobe
                  // R18: drivers off during a read
                  // R10: same pins now carry data
                  ad_out <= wdata;
                  ad_oe  <= is_write;
                  rd_n   <= is_write;
                  wr_n   <= !is_write;
               end
            end
            ST_STRB: begin
               if (tdone) begin
                  // two sync flops: pins are seen two clocks late, so
                  // strobes shorter than three clocks read stale pins
                  if (!is_write) begin
                     move_rdata <= ad_sync2;
                  end
                  rd_n <= 1'b1;
                  wr_n <= 1'b1;
               end
            end
            ST_TAIL: begin
               // request cycle plus three tail clocks give the fixed four
               // R16: fixed overhead tail before release
               if (tdone) begin
                  pins_claimed <= 1'b0;
                  move_busy    <= 1'b0;
                  move_done    <= 1'b1;
                  ad_oe        <= 1'b0;
                  addr_lo_oe   <= 1'b0;
                  addr_hi_oe   <= 1'b0;
               end
            end
            default: begin
               ale <= 1'b0;
            end
         endcase
      end
   end
endmodule // emb_cfg
`default_nettype wire

// >>> rtl/emb_cfg_regs.vh
`ifndef EMB_CFG_REGS_VH
`define EMB_CFG_REGS_VH
// configuration register address and layout
`define EMB_CFG_ADDR      8'hB2
`define EMB_PAGE_ADDR     8'hAA
`define EMB_CFG_RESET     8'h03
`define EMB_PAGE_RESET    8'h00
`define EMB_CFG_WMASK     8'h1F
`define EMB_MUX_BIT       4
`define EMB_MODE_HI       3
`define EMB_MODE_LO       2
`define EMB_ALE_HI        1
`define EMB_ALE_LO        0
// memory map modes
`define EMB_MODE_INT      2'h0
`define EMB_MODE_SPLIT_NB 2'h1
`define EMB_MODE_SPLIT_B  2'h2
`define EMB_MODE_EXT      2'h3
// on-chip size boundary: 4 kB, address bits above 11 select off-chip
`define EMB_ONCHIP_BITS   12
`define EMB_ONCHIP_MASK   16'h0FFF
// fixed overhead of an off-chip move in core clocks
`define EMB_MOVE_OVERHEAD 3'h4
`define EMB_STROBE_CYCLES 4'h1
`endif

// >>> rtl/emb_pulse_timer.v
`timescale 1ns/10ps
`default_nettype none
// loadable down counter; done when it reaches zero
module emb_pulse_timer (
   input  wire       core_clk,
   input  wire       rst_n,
   input  wire       load,
   input  wire [3:0] count_in,
   output wire       done
);
   reg [3:0] count;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 4'h0;
      end else if (load) begin
         count <= count_in;
      end else if (count != 4'h0) begin
         count <= count - 4'h1;
      end
   end
   // no load term: callers decode their load from done, a load term would loop
   assign done = (count == 4'h0);
endmodule // emb_pulse_timer
`default_nettype wire

// >>> tb/emb_cfg_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "emb_cfg_regs.vh"
module emb_cfg_chk (
   input wire logic        core_clk, rst_n, sfr_wr, move_req, move_8bit,
   input wire logic        move_busy, move_done, move_onchip, ale, rd_n,
   input wire logic        wr_n, ad_oe, addr_lo_oe, addr_hi_oe, pins_claimed,
   input wire logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, move_wdata,
   input wire logic [7:0]  ad_out, addr_lo_out, addr_hi_out,
   input wire logic [15:0] move_addr,
   input wire logic [11:0] onchip_addr
);
   logic [7:0]  cfg, page, lw;
   logic [15:0] la;
   logic        l8;
   logic [2:0]  acnt;
   wire         take = move_req && !move_busy;
   wire [15:0]  ea = move_8bit ? {page, move_addr[7:0]} : move_addr;
   wire         strb = !rd_n || !wr_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= `EMB_CFG_RESET;
         page <= `EMB_PAGE_RESET;
         acnt <= 3'h0;
      end else begin
         if (sfr_wr && sfr_addr == `EMB_CFG_ADDR) cfg <= sfr_wdata & `EMB_CFG_WMASK;
         if (sfr_wr && sfr_addr == `EMB_PAGE_ADDR) page <= sfr_wdata;
         acnt <= ale ? acnt + 3'h1 : 3'h0;
      end
   end
   // request fields kept for the whole move
   always_ff @(posedge core_clk) begin
      if (take) begin
         la <= ea;
         lw <= move_wdata;
         l8 <= move_8bit;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   AST_ONE_STROBE: assert property (!(!rd_n && !wr_n))
      else $error("both strobes low");
   AST_ALE_WIDTH: assert property ($fell(ale) |-> acnt == {1'b0, cfg[1:0]} + 3'h1)
      else $error("latch strobe width");
   AST_ALE_MUX_ONLY: assert property (cfg[4] |-> !ale)
      else $error("latch strobe in split bus");
   AST_ALE_ADDR: assert property (ale |-> ad_oe && ad_out == la[7:0])
      else $error("low address not on shared pins");
   AST_WR_DATA: assert property (!wr_n |-> ad_oe && ad_out == lw)
      else $error("write data not driven");
   AST_RD_FLOAT: assert property (!rd_n |-> !ad_oe)
      else $error("data driven during read");
   AST_RELEASE: assert property (!move_busy |-> !pins_claimed && !ad_oe && !addr_hi_oe)
      else $error("pins held while idle");
   AST_INT_ONLY: assert property (take && cfg[3:2] == `EMB_MODE_INT |=>
      move_onchip && move_done && onchip_addr == la[11:0])
      else $error("internal mode move");
   AST_EXT_ONLY: assert property (take && cfg[3:2] == `EMB_MODE_EXT |=> !move_onchip)
      else $error("external mode went on-chip");
   AST_SPLIT_ROUTE: assert property (take && cfg[3] != cfg[2] |=>
      move_onchip == (la < 16'h1000))
      else $error("split mode route");
   AST_SEP_ADDR: assert property (strb && cfg[4] |-> addr_lo_oe && addr_lo_out == la[7:0])
      else $error("separate low address");
   AST_BANK_HI: assert property (strb && (cfg[3:2] == `EMB_MODE_SPLIT_B || !l8) |->
      addr_hi_oe && addr_hi_out == la[15:8])
      else $error("upper address");
   AST_PORT_HI: assert property (strb && l8 && cfg[2] |-> !addr_hi_oe)
      else $error("upper address driven");
   AST_CFG_RD: assert property (sfr_addr == `EMB_CFG_ADDR |=> sfr_rdata == $past(cfg))
      else $error("unused bits read");
endmodule // emb_cfg_chk
bind emb_cfg emb_cfg_chk emb_cfg_chk_i (.core_clk(core_clk), .rst_n(rst_n),
   .sfr_wr(sfr_wr), .move_req(move_req), .move_8bit(move_8bit), .move_busy(move_busy),
   .move_done(move_done), .move_onchip(move_onchip), .ale(ale), .rd_n(rd_n),
   .wr_n(wr_n), .ad_oe(ad_oe), .addr_lo_oe(addr_lo_oe), .addr_hi_oe(addr_hi_oe),
   .pins_claimed(pins_claimed), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .sfr_rdata(sfr_rdata), .move_wdata(move_wdata), .ad_out(ad_out),
   .addr_lo_out(addr_lo_out), .addr_hi_out(addr_hi_out), .move_addr(move_addr),
   .onchip_addr(onchip_addr));
`default_nettype wire

// >>> tb/emb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module emb_mem_model (
   input  wire logic       core_clk, mux, ale, rd_n, wr_n, addr_hi_oe,
   input  wire logic [7:0] ad_out, addr_lo_out, addr_hi_out,
   output wire logic [7:0] ad_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] lat, q;
   logic [1:0] hold = 2'h0;
   // upper lines parked high by the port latches when not driven
   wire [15:0] a = {addr_hi_oe ? addr_hi_out : 8'hFF, mux ? lat : addr_lo_out};
   always_latch if (ale) lat = ad_out;
   always @(posedge core_clk) begin
      if (!wr_n) mem[a] <= ad_out;
      if (!rd_n) begin
         q <= mem[a];
         hold <= 2'h3;
      end else if (hold != 2'h0) hold <= hold - 2'h1;
      else q <= ~q;
   end
   assign ad_in = !rd_n ? mem[a] : q;
endmodule // emb_mem_model
`default_nettype wire

// >>> tb/tb_emb_cfg.sv
`timescale 1ns/10ps
`default_nettype none
`include "emb_cfg_regs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, a, b); end end
module tb_emb_cfg;
   logic core_clk = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, move_req = 1'b0;
   logic move_write = 1'b0, move_8bit = 1'b0, e;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, move_wdata = 8'h00, cfg, page, d;
   logic [7:0] ad_in, sfr_rdata, move_rdata, ad_out, addr_lo_out, addr_hi_out;
   logic [15:0] move_addr = 16'h0000, a;
   logic [3:0] strobe_width = 4'h2;
   logic [11:0] onchip_addr;
   logic move_done, move_onchip, move_busy, ale, rd_n, wr_n;
   logic ad_oe, addr_lo_oe, addr_hi_oe, pins_claimed;
   int error_cnt = 0, samples_checked = 0;
   always #20 core_clk = ~core_clk;
   emb_cfg emb_cfg_i (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .move_req(move_req),
      .move_write(move_write), .move_8bit(move_8bit), .move_addr(move_addr),
      .move_wdata(move_wdata), .strobe_width(strobe_width), .move_done(move_done),
      .move_onchip(move_onchip), .onchip_addr(onchip_addr), .move_rdata(move_rdata),
      .move_busy(move_busy), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .ad_out(ad_out),
      .ad_oe(ad_oe), .ad_in(ad_in), .addr_lo_out(addr_lo_out), .addr_lo_oe(addr_lo_oe),
      .addr_hi_out(addr_hi_out), .addr_hi_oe(addr_hi_oe), .pins_claimed(pins_claimed));
   emb_mem_model emb_mem_model_i (.core_clk(core_clk), .mux(!cfg[4]), .ale(ale),
      .rd_n(rd_n), .wr_n(wr_n), .addr_hi_oe(addr_hi_oe), .ad_out(ad_out),
      .addr_lo_out(addr_lo_out), .addr_hi_out(addr_hi_out), .ad_in(ad_in));
   ////////////////////////////////////////
   task automatic sfr(input logic [7:0] ra, rd, input logic w);
      sfr_addr = ra;
      sfr_wdata = rd;
      if (w) sfr_wr = 1'b1;
      @(posedge core_clk);
      #1 if (w) sfr_wr = 1'b0;
   endtask
   task automatic mv(input logic w);
      logic [15:0] ea;
      logic on;
      int n;
      ea = e ? {page, a[7:0]} : a;
      on = cfg[3:2] == 2'h0 || (cfg[3:2] != 2'h3 && ea < 16'h1000);
      {move_req, move_write, move_8bit, move_addr, move_wdata} = {1'b1, w, e, a, d};
      strobe_width = 4'($urandom_range(5, 2));
      @(posedge core_clk);
      #1 move_req = 1'b0;
      n = 0;
      // done stands one cycle, possibly right after the taking edge
      while (move_done !== 1'b1 && n < 40) begin
         @(posedge core_clk);
         #1 n++;
      end
      `CHK(move_onchip, on)
      // n counts edges after the taking one: latch phases, strobe, overhead of four
      `CHK(n, on ? 0 : (cfg[4] ? 0 : 2 * (cfg[1:0] + 1)) + (strobe_width + 1) + 4 - 1)
      if (!on && !w) `CHK(move_rdata, d)
      // one idle edge so the next request never follows in the same time step
      @(posedge core_clk);
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      cfg = `EMB_CFG_RESET;
      page = `EMB_PAGE_RESET;
      void'($urandom(24109));
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1'b1;
      sfr(`EMB_CFG_ADDR, 8'h00, 1'b0);
      `CHK(sfr_rdata, `EMB_CFG_RESET)
      sfr(`EMB_PAGE_ADDR, 8'h00, 1'b0);
      `CHK(sfr_rdata, `EMB_PAGE_RESET)
      for (int c = 0; c < 32; c++) begin
         sfr(`EMB_CFG_ADDR, 8'(c) | 8'hE0, 1'b1);
         cfg = 8'(c);
         sfr(`EMB_CFG_ADDR, 8'h00, 1'b0);
         `CHK(sfr_rdata, cfg)
         // page on both sides of the boundary
         page = c[0] ? 8'h0F + 8'(c[1]) : 8'($urandom);
         sfr(`EMB_PAGE_ADDR, page, 1'b1);
         for (int k = 0; k < 4; k++) begin
            a = k == 0 ? 16'h1000 - 16'(c[1]) : 16'($urandom);
            e = 1'($urandom);
            d = 8'($urandom);
            mv(1'b1);
            mv(1'b0);
         end
      end
      final_report;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      final_report;
   end
endmodule // tb_emb_cfg
`default_nettype wire
